// >>> core/system_control_and_table_regs.v
`include "sysreg_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module system_control_and_table_regs
#(
   parameter ADDR_W = 32                      // Linear address width
)
(
   input  wire              sys_clk,
   input  wire              rst_b,
   // Register access from instruction execution
   input  wire              reg_wr,           // Move/load to a system register
   input  wire              reg_rd,           // Move/store from a system register
   input  wire [2:0]        reg_sel,          // Which register
   input  wire [47:0]       reg_wdata,        // Write data (pointers use 48 bits)
   input  wire              op16,             // 16-bit operand size on the load
   input  wire [1:0]        cur_priv,         // Current privilege level
   output reg  [47:0]       reg_rdata_ff,     // Read data
   output reg               reg_fault_ff,     // Privilege fault on the access
   // Execution events
   input  wire              task_switch,      // A task switch completed
   input  wire              float_op,         // A floating-point op issues
   input  wire              wait_op,          // A WAIT op issues
   input  wire              mem_write,        // A memory write issues
   input  wire              page_read_only,   // Target page is read-only
   input  wire              misaligned,       // Access is misaligned
   input  wire              alignment_check_flag,
   input  wire              page_fault,       // Translation failed
   input  wire [ADDR_W-1:0] fault_addr,       // Linear address of that access
   output reg               exc_valid_ff,     // Exception raised this cycle
   output reg  [7:0]        exc_vector_ff,    // Its vector
   // Mode outputs
   output reg               prot_mode_ff,
   output reg               paging_on_ff,
   output reg               cache_fill_ok_ff,
   output reg  [31:0]       page_dir_ff,
   // Segment selector lookup
   input  wire              seg_load,         // Segment register load
   input  wire [15:0]       seg_selector,
   output reg  [31:0]       tbl_base_ff,      // Table base picked for lookup
   output reg  [31:0]       dsc_addr_ff,      // Byte address of descriptor
   output reg               seg_null_ff,      // Null global entry picked
   // Descriptor fetch answers for local-table load and checks
   input  wire              dsc_valid,        // Descriptor words returned
   input  wire [31:0]       dsc_lo,
   input  wire [31:0]       dsc_hi,
   input  wire              dsc_from_local,   // Descriptor came from local table
   output reg               dsc_reject_ff,    // System descriptor outside global
   output reg  [31:0]       dsc_base_ff,      // Assembled segment base
   output reg  [31:0]       dsc_limit_ff,     // Scaled segment limit
   output reg               ldt_fetch_ff,     // Request fetch for local selector
   output reg  [31:0]       ldt_base_ff,      // Hidden cached local table base
   output reg  [31:0]       ldt_limit_ff      // Hidden cached local table limit
);

   // Overview of the state kept here
   // The control word sets the mode for everything else in the block
   // The fault address is written by hardware on a page fault
   // The directory base keeps only its page-aligned upper part
   // Both table pointers carry a base above a limit
   // The local selector owns a hidden copy of its descriptor
   // That hidden copy is filled once per reload, never refreshed
   // so software must reload the selector after editing the table
   // All state sits on the one core clock
   // Reset puts the block into real mode with paging off
   // Outputs are registered, so callers see one cycle of latency
   // Architectural registers
   reg [31:0] ctl_ff;                          // Control flags word
   reg [31:0] fla_ff;                          // Fault linear address
   reg [31:0] pdb_ff;                          // Page directory base
   reg [47:0] gtp_ff;                          // Global pointer {base,limit}
   reg [47:0] itp_ff;                          // Interrupt pointer {base,limit}
   reg [15:0] lts_ff;                          // Local selector
   reg        ldt_wait_ff;                     // Awaiting hidden-part fill

   // Next values
   reg [31:0] nxt_ctl;
   reg [47:0] nxt_gtp;
   reg        acc_ok;
   reg        priv_ok;
   reg        exc;
   reg [7:0]  vec;
   reg [31:0] base_asm;
   reg [31:0] lim_raw;
   reg [15:0] sel_use;
   reg [31:0] sel_base;

   wire prot = ctl_ff[`CTL_PROT_BIT];
   wire pg_en = ctl_ff[`CTL_PAGE_BIT] & prot;

   // Privilege model
   // Reads of the control and table registers are open at any level
   // Writes in protected mode need level zero
   // Real mode has no levels, so every write except to the local selector is let through there
   // The local selector has no meaning in real mode at all
   // so both its load and its store are refused there
   // A refused access changes nothing and raises the access fault
   // The check is combinational so the write enable can use it
   // in the same cycle as the request
   // Access checks: level zero writes, table loads privileged, local only protected
   always @*
   begin
      priv_ok = ~prot | (cur_priv == 2'b00);
      acc_ok  = 1'b1;
      if (reg_wr && reg_sel != `SEL_LTS)
         acc_ok = priv_ok;
      if ((reg_wr || reg_rd) && reg_sel == `SEL_LTS)
         acc_ok = prot && (!reg_wr || priv_ok);
   end

   // Control word update
   // Only the defined flag bits take write data
   // Reserved bits are forced, so careless software cannot corrupt them
   // The status-word path touches the low half only
   // The upper flags are kept as they were on that path
   // A task switch sets the switched flag in hardware
   // Control word merge: fixed reserved bits, low half via status word
   always @*
   begin
      nxt_ctl = ctl_ff;
      if (reg_wr && acc_ok && reg_sel == `SEL_CTL)
         nxt_ctl = (reg_wdata[31:0] & `CTL_WR_MASK) | `CTL_RESET;
      else if (reg_wr && acc_ok && reg_sel == `SEL_MSW)
         nxt_ctl = {ctl_ff[31:16], (reg_wdata[15:0] & 16'h000F) | 16'h0010};
      // Hardware set wins over any clear in the same cycle
      if (task_switch)
         nxt_ctl[`CTL_TSW_BIT] = 1'b1;
   end

   // Global pointer update
   // The full 48-bit word arrives in one request
   // A short operand still fetches a full base word
   // but its top byte must not survive, leaving a 24-bit base
   // Global pointer load; 16-bit operand drops the top base byte
   always @*
   begin
      nxt_gtp = gtp_ff;
      if (reg_wr && acc_ok && reg_sel == `SEL_GTP)
      begin
         if (op16)
            nxt_gtp = {8'h00, reg_wdata[39:0]};
         else
            nxt_gtp = reg_wdata;
      end
   end

   // Fault priority
   // Coprocessor traps come first, since they stop the op at issue
   // The WAIT check only matters with the monitor bit set
   // Page faults need paging to be on, or there is no translation
   // Read-only writes use the same vector as page faults
   // With the guard bit clear only the user level is stopped
   // Alignment faults need both the mask and the flag
   // Register access faults come last
   // Only one fault is reported per cycle
   // A lower-priority event in the same cycle is dropped here
   // and the core is expected to retry it after the handler
   // Fault decision, checked against the current (already applied) word
   always @*
   begin
      exc = 1'b0;
      vec = 8'h00;
      if (float_op && (ctl_ff[`CTL_FTRAP_BIT] || ctl_ff[`CTL_TSW_BIT]))
      begin
         exc = 1'b1;
         vec = `FAULT_VEC_NM;
      end
      else if (wait_op && ctl_ff[`CTL_WMON_BIT] && ctl_ff[`CTL_TSW_BIT])
      begin
         exc = 1'b1;
         vec = `FAULT_VEC_NM;
      end
      else if (page_fault && pg_en)
      begin
         exc = 1'b1;
         vec = `FAULT_VEC_PF;
      end
      else if (mem_write && page_read_only && pg_en &&
               (ctl_ff[`CTL_WPROT_BIT] || cur_priv == 2'b11))
      begin
         exc = 1'b1;
         vec = `FAULT_VEC_PF;
      end
      else if (misaligned && ctl_ff[`CTL_AMASK_BIT] && alignment_check_flag)
      begin
         exc = 1'b1;
         vec = `FAULT_VEC_AC;
      end
      else if ((reg_wr || reg_rd) && !acc_ok)
      begin
         exc = 1'b1;
         vec = `FAULT_VEC_GP;
      end
   end

   // Descriptor lookup
   // A segment load picks its table from the selector's pick bit
   // Without a segment load the local selector is looked up
   // and that lookup always uses the global table
   // Each descriptor is eight bytes wide
   // Selector lookup: pick bit chooses the table, index scales by eight
   always @*
   begin
      sel_use  = seg_load ? seg_selector : lts_ff;
      sel_base = gtp_ff[47:16];
      if (seg_load && sel_use[`SELR_PICK_BIT])
         sel_base = ldt_base_ff;
   end

   // Descriptor decode
   // The base is spread over both descriptor words
   // The limit is twenty bits, optionally scaled to pages
   // Page scale fills the low twelve bits with ones
   // so the last byte of the last page stays reachable
   // Descriptor base and limit assembly
   always @*
   begin
      base_asm = {dsc_hi[31:24], dsc_hi[7:0], dsc_lo[31:16]};
      lim_raw  = {12'h000, dsc_hi[19:16], dsc_lo[15:0]};
      if (dsc_hi[`DSC_GRAN_BIT])
         lim_raw = {lim_raw[19:0], 12'hFFF};
   end

   // Register state
   // A write lands at the edge that takes it
   // so the next instruction already sees the new value
   // A page fault overrides a software write of the fault address
   // The hidden local part waits for a system descriptor
   // Application descriptors do not fill it
   // Register state; every write is visible to the next instruction
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctl_ff      <= `CTL_RESET;
         fla_ff      <= 32'h00000000;
         pdb_ff      <= 32'h00000000;
         gtp_ff      <= 48'h000000000000;
         itp_ff      <= 48'h000000000000;
         lts_ff      <= 16'h0000;
         ldt_wait_ff <= 1'b0;
         ldt_base_ff <= 32'h00000000;
         ldt_limit_ff <= 32'h00000000;
      end
      else
      begin
         ctl_ff <= nxt_ctl;
         gtp_ff <= nxt_gtp;
         if (page_fault && pg_en)
            fla_ff <= fault_addr;
         else if (reg_wr && acc_ok && reg_sel == `SEL_FLA)
            fla_ff <= reg_wdata[31:0];
         if (reg_wr && acc_ok && reg_sel == `SEL_PDB)
            pdb_ff <= reg_wdata[31:0] & `PDB_MASK;
         if (reg_wr && acc_ok && reg_sel == `SEL_ITP)
            itp_ff <= reg_wdata;
         if (reg_wr && acc_ok && reg_sel == `SEL_LTS)
         begin
            lts_ff      <= reg_wdata[15:0];
            ldt_wait_ff <= 1'b1;
         end
         else if (ldt_wait_ff && dsc_valid && !dsc_hi[`DSC_APP_BIT])
         begin
            // Hidden part is only refilled on reload, never re-read
            ldt_base_ff  <= base_asm;
            ldt_limit_ff <= lim_raw;
            ldt_wait_ff  <= 1'b0;
         end
      end
   end

   // Output stage
   // Every output is a flip-flop, so no combinational path leaves the block
   // Pulses last exactly one cycle
   // Read data holds until the next good read
   // Mode levels trail the control word by one cycle
   // Cache fills are allowed out of reset
   // Outputs, all registered
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata_ff     <= 48'h000000000000;
         reg_fault_ff     <= 1'b0;
         exc_valid_ff     <= 1'b0;
         exc_vector_ff    <= 8'h00;
         prot_mode_ff     <= 1'b0;
         paging_on_ff     <= 1'b0;
         cache_fill_ok_ff <= 1'b1;
         page_dir_ff      <= 32'h00000000;
         tbl_base_ff      <= 32'h00000000;
         dsc_addr_ff      <= 32'h00000000;
         seg_null_ff      <= 1'b0;
         dsc_reject_ff    <= 1'b0;
         dsc_base_ff      <= 32'h00000000;
         dsc_limit_ff     <= 32'h00000000;
         ldt_fetch_ff     <= 1'b0;
      end
      else
      begin
         reg_fault_ff  <= (reg_wr || reg_rd) && !acc_ok;
         exc_valid_ff  <= exc;
         exc_vector_ff <= vec;
         // Reads are open at every level; only the local selector needs protection
         if (reg_rd && acc_ok)
         begin
            case (reg_sel)
               `SEL_CTL: reg_rdata_ff <= {16'h0000, ctl_ff};
               `SEL_FLA: reg_rdata_ff <= {16'h0000, fla_ff};
               `SEL_PDB: reg_rdata_ff <= {16'h0000, pdb_ff};
               `SEL_GTP: reg_rdata_ff <= gtp_ff;
               `SEL_ITP: reg_rdata_ff <= itp_ff;
               `SEL_LTS: reg_rdata_ff <= {32'h00000000, lts_ff};
               `SEL_MSW: reg_rdata_ff <= {32'h00000000, ctl_ff[15:0]};
               default:  reg_rdata_ff <= 48'h000000000000;
            endcase
         end
         prot_mode_ff     <= prot;
         paging_on_ff     <= pg_en;
         cache_fill_ok_ff <= ~ctl_ff[`CTL_CFOFF_BIT];
         page_dir_ff      <= pdb_ff;
         // Lookup address; local selector loads always go to the global table
         tbl_base_ff <= sel_base;
         dsc_addr_ff <= sel_base + {16'h0000, sel_use[15:3], 3'b000};
         seg_null_ff <= seg_load && !sel_use[`SELR_PICK_BIT] &&
                        (sel_use[15:3] == 13'h0000);
         ldt_fetch_ff <= reg_wr && acc_ok && (reg_sel == `SEL_LTS);
         // System descriptors are only legal when taken from the global table
         dsc_reject_ff <= dsc_valid && dsc_from_local && !dsc_hi[`DSC_APP_BIT];
         if (dsc_valid)
         begin
            dsc_base_ff  <= base_asm;
            dsc_limit_ff <= lim_raw;
         end
      end
   end

endmodule
`default_nettype wire

// >>> core/sysreg_defines.vh
`ifndef SYSREG_DEFINES_VH
`define SYSREG_DEFINES_VH
// Control word bit positions
`define CTL_PROT_BIT      0
`define CTL_WMON_BIT      1
`define CTL_FTRAP_BIT     2
`define CTL_TSW_BIT       3
`define CTL_RSV1_BIT      4
`define CTL_RSV0A_BIT     5
`define CTL_WPROT_BIT     16
`define CTL_AMASK_BIT     18
`define CTL_RSV0B_BIT     29
`define CTL_CFOFF_BIT     30
`define CTL_PAGE_BIT      31
// Control word reset value: only the fixed-one reserved bit set
`define CTL_RESET         32'h00000010
// Mask of bits that software may change in the control word
`define CTL_WR_MASK       32'hC005000F
// Register select codes for the instruction-side port
`define SEL_CTL           3'h0
`define SEL_FLA           3'h1
`define SEL_PDB           3'h2
`define SEL_GTP           3'h3
`define SEL_ITP           3'h4
`define SEL_LTS           3'h5
`define SEL_MSW           3'h6
// Page directory base keeps its top 20 bits only
`define PDB_MASK          32'hFFFFF000
// Selector fields
`define SELR_PICK_BIT     2
// Descriptor fields, high word
`define DSC_GRAN_BIT      23
`define DSC_APP_BIT       12
// Vectors used for the coprocessor-absent, protection, page and alignment faults
`define FAULT_VEC_NM      8'h07
`define FAULT_VEC_GP      8'h0D
`define FAULT_VEC_PF      8'h0E
`define FAULT_VEC_AC      8'h11
`endif

// >>> testbench/sysreg_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level relations of the system register block
module sysreg_chk
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [2:0]  reg_sel,
   input wire logic [1:0]  cur_priv,
   input wire logic        reg_fault_ff,
   input wire logic        prot_mode_ff,
   input wire logic        paging_on_ff,
   input wire logic [31:0] page_dir_ff,
   input wire logic        seg_load,
   input wire logic [15:0] seg_selector,
   input wire logic [31:0] tbl_base_ff,
   input wire logic [31:0] dsc_addr_ff,
   input wire logic        seg_null_ff,
   input wire logic        dsc_valid,
   input wire logic [31:0] dsc_lo,
   input wire logic [31:0] dsc_hi,
   input wire logic        dsc_from_local,
   input wire logic        dsc_reject_ff,
   input wire logic [31:0] dsc_base_ff,
   input wire logic [31:0] dsc_limit_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_priv_wr_fault: assert property (
      reg_wr && prot_mode_ff && cur_priv != 2'h0 |=> reg_fault_ff) else $error("write not refused");
   a_local_real_fault: assert property (
      (reg_wr || reg_rd) && reg_sel == 3'h5 && !prot_mode_ff |=> reg_fault_ff) else $error("local access ok");
   a_paging_needs_prot: assert property (
      paging_on_ff |-> prot_mode_ff) else $error("paging without protection");
   a_pdb_aligned: assert property (
      page_dir_ff[11:0] == 12'h000) else $error("directory base unaligned");
   a_desc_addr_calc: assert property (
      seg_load |=> dsc_addr_ff == tbl_base_ff + {16'h0000, $past(seg_selector[15:3]), 3'h0})
      else $error("descriptor address wrong");
   a_null_entry_flag: assert property (
      seg_load |=> seg_null_ff == ($past(seg_selector[15:2]) == 14'h0000)) else $error("null flag wrong");
   a_base_assembly: assert property (
      dsc_valid |=> dsc_base_ff == {$past(dsc_hi[31:24]), $past(dsc_hi[7:0]), $past(dsc_lo[31:16])})
      else $error("base wrong");
   a_limit_scale: assert property (
      dsc_valid |=> dsc_limit_ff == ($past(dsc_hi[23]) ? {$past(dsc_hi[19:16]), $past(dsc_lo[15:0]), 12'hFFF}
      : {12'h000, $past(dsc_hi[19:16]), $past(dsc_lo[15:0])})) else $error("limit wrong");
   a_system_desc_reject: assert property (
      dsc_valid |=> dsc_reject_ff == ($past(dsc_from_local) && !$past(dsc_hi[12]))) else $error("reject wrong");
endmodule
bind system_control_and_table_regs sysreg_chk sysreg_chk_i (.sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_sel,
   .cur_priv, .reg_fault_ff, .prot_mode_ff, .paging_on_ff, .page_dir_ff, .seg_load, .seg_selector, .tbl_base_ff,
   .dsc_addr_ff, .seg_null_ff, .dsc_valid, .dsc_lo, .dsc_hi, .dsc_from_local, .dsc_reject_ff, .dsc_base_ff,
   .dsc_limit_ff);
`default_nettype wire

// >>> testbench/tb_system_control_and_table_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_system_control_and_table_regs;
   logic        sys_clk, rst_b, reg_wr, reg_rd, op16, clr;
   logic [2:0]  reg_sel;
   logic [1:0]  cur_priv;
   logic [47:0] reg_wdata, reg_rdata_ff;
   logic [7:0]  ev_in, exc_vector_ff, vx;          // Event bundle and captured vector
   logic [31:0] fault_addr, dsc_lo, dsc_hi, page_dir_ff, tbl_base_ff, dsc_addr_ff;
   logic [31:0] dsc_base_ff, dsc_limit_ff, ldt_base_ff, ldt_limit_ff;
   logic [15:0] seg_selector;
   logic        reg_fault_ff, exc_valid_ff, prot_mode_ff, paging_on_ff, cache_fill_ok_ff;
   logic        seg_load, seg_null_ff, dsc_valid, dsc_from_local, dsc_reject_ff, ldt_fetch_ff;
   logic [3:0]  saw;                               // Sticky pulses, so one-cycle outputs are never missed
   int          n_mismatch, samples_checked, i;
   // Write select, op16, read select, write data, expected read
   logic [102:0] rows [0:7] = '{
      {3'h0, 1'b0, 3'h0, 48'hFFFFFFFF, 48'hC005001F}, {3'h0, 1'b0, 3'h6, 48'h1, 48'h11},
      {3'h2, 1'b0, 3'h2, 48'h12345FFF, 48'h12345000}, {3'h1, 1'b0, 3'h1, 48'hDEADBEEF, 48'hDEADBEEF},
      {3'h3, 1'b1, 3'h3, 48'h123456789ABC, 48'h003456789ABC}, {3'h3, 1'b0, 3'h3, 48'h123456789ABC, 48'h123456789ABC},
      {3'h4, 1'b0, 3'h4, 48'hFEDCBA987654, 48'hFEDCBA987654}, {3'h5, 1'b0, 3'h5, 48'hA5A8, 48'hA5A8}};
   system_control_and_table_regs system_control_and_table_regs_i (
      .sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .op16, .cur_priv, .reg_rdata_ff, .reg_fault_ff,
      .task_switch(ev_in[7]), .float_op(ev_in[6]), .wait_op(ev_in[5]), .mem_write(ev_in[4]),
      .page_read_only(ev_in[3]), .misaligned(ev_in[2]), .alignment_check_flag(ev_in[1]), .page_fault(ev_in[0]),
      .fault_addr, .exc_valid_ff, .exc_vector_ff, .prot_mode_ff, .paging_on_ff, .cache_fill_ok_ff, .page_dir_ff,
      .seg_load, .seg_selector, .tbl_base_ff, .dsc_addr_ff, .seg_null_ff, .dsc_valid, .dsc_lo, .dsc_hi,
      .dsc_from_local, .dsc_reject_ff, .dsc_base_ff, .dsc_limit_ff, .ldt_fetch_ff, .ldt_base_ff, .ldt_limit_ff);
   initial
   begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Pulse capture, cleared at the start of each acc, ev and dsc operation
   always @(posedge sys_clk)
   begin
      saw <= clr ? 4'h0 : saw | {reg_fault_ff, exc_valid_ff, dsc_reject_ff, ldt_fetch_ff};
      vx <= clr ? 8'h00 : (exc_valid_ff ? exc_vector_ff : vx);
   end
   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Optional write, then an optional read on the very next cycle
   task acc(input logic w, r, input logic [2:0] ws, input logic [47:0] d, input logic o, input logic [2:0] rs);
      @(negedge sys_clk);
      clr = 1;
      reg_wr = w;
      reg_sel = ws;
      reg_wdata = d;
      op16 = o;
      @(negedge sys_clk);
      clr = 0;
      reg_wr = 0;
      reg_rd = r;
      reg_sel = rs;
      @(negedge sys_clk);
      reg_rd = 0;
      repeat (2) @(negedge sys_clk);
   endtask
   // One-cycle event; vector FF means only the raise is checked
   task ev(input logic [7:0] e, input logic [8:0] x);
      @(negedge sys_clk);
      clr = 1;
      ev_in = e;
      @(negedge sys_clk);
      clr = 0;
      ev_in = 0;
      repeat (2) @(negedge sys_clk);
      chk("exc", x, {saw[2], (x[7:0] == 8'hFF) ? 8'hFF : vx});
   endtask
   task dsc(input logic [31:0] lo, hi, input logic loc);
      @(negedge sys_clk);
      clr = 1;
      dsc_valid = 1;
      dsc_lo = lo;
      dsc_hi = hi;
      dsc_from_local = loc;
      @(negedge sys_clk);
      clr = 0;
      dsc_valid = 0;
      repeat (2) @(negedge sys_clk);
   endtask
   task seg(input logic [15:0] s);
      @(negedge sys_clk);
      seg_load = 1;
      seg_selector = s;
      @(negedge sys_clk);
      seg_load = 0;
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      {rst_b, reg_wr, reg_rd, op16, clr, reg_sel, cur_priv, reg_wdata, ev_in, seg_load, seg_selector} = '0;
      {fault_addr, dsc_lo, dsc_hi, dsc_valid, dsc_from_local, n_mismatch, samples_checked} = '0;
      repeat (12) @(negedge sys_clk);
      rst_b = 1;
      acc(0, 1, 3'h0, 0, 0, 3'h0);
      chk("ctl_rst", 48'h10, reg_rdata_ff);
      chk("fill_rst", 1, cache_fill_ok_ff);
      acc(0, 1, 3'h0, 0, 0, 3'h5);
      chk("lts_real", 1, saw[3]);
      acc(1, 0, 3'h0, 48'h80000000, 0, 3'h0);
      chk("pg_no_pe", 0, {paging_on_ff, prot_mode_ff});
      for (i = 0; i < 8; i++)
      begin
         acc(1, 1, rows[i][102:100], rows[i][95:48], rows[i][99], rows[i][98:96]);
         chk("readback", rows[i][47:0], reg_rdata_ff);
      end
      chk("ldt_fetch", 3, {prot_mode_ff, saw[0]});
      chk("page_dir", 48'h12345000, page_dir_ff);
      acc(1, 0, 3'h0, 48'hC0000001, 0, 3'h0);
      chk("pg_fill", 2, {paging_on_ff, cache_fill_ok_ff});
      fault_addr = 32'hCAFEF00D;
      ev(8'h01, 9'h10E);
      acc(0, 1, 3'h0, 0, 0, 3'h1);
      chk("fla", 48'hCAFEF00D, reg_rdata_ff);
      cur_priv = 2'h3;
      acc(1, 1, 3'h0, 0, 0, 3'h0);
      chk("refused", 48'h1C0000011, {saw[3], reg_rdata_ff[31:0]});
      chk("gp_vec", 48'h0D, vx);
      cur_priv = 2'h0;
      acc(1, 0, 3'h0, 48'h5, 0, 3'h0);
      ev(8'h40, 9'h107);
      acc(1, 0, 3'h0, 48'h3, 0, 3'h0);
      ev(8'h20, 9'h000);
      ev(8'h80, 9'h000);
      acc(0, 1, 3'h0, 0, 0, 3'h0);
      chk("ts_set", 48'h1B, reg_rdata_ff);
      ev(8'h20, 9'h107);
      acc(1, 0, 3'h0, 48'h9, 0, 3'h0);
      ev(8'h40, 9'h107);
      ev(8'h20, 9'h000);
      acc(1, 0, 3'h0, 48'h40001, 0, 3'h0);
      ev(8'h06, 9'h111);
      ev(8'h04, 9'h000);
      acc(1, 0, 3'h0, 48'h80000001, 0, 3'h0);
      ev(8'h06, 9'h000);
      cur_priv = 2'h1;
      ev(8'h18, 9'h000);
      cur_priv = 2'h3;
      ev(8'h18, 9'h1FF);
      cur_priv = 2'h0;
      acc(1, 0, 3'h0, 48'h80010001, 0, 3'h0);
      ev(8'h18, 9'h1FF);
      dsc(32'h00CDFFFF, 32'hAB0F0200, 0);
      chk("ldt_hidden", 48'hAB0000CD, ldt_base_ff);
      chk("ldt_limit", 48'hFFFFF, ldt_limit_ff);
      dsc(32'h00CDFFFF, 32'h128F1200, 1);
      chk("app_local", 48'h0FFFFFFFF, {saw[1], dsc_limit_ff});
      chk("ldt_kept", 48'hAB0000CD, ldt_base_ff);
      dsc(32'h00CDFFFF, 32'hAB0F0200, 1);
      chk("sys_local", 1, saw[1]);
      seg(16'h002B);
      chk("gdt_pick", 48'h5678123456A0, {tbl_base_ff[15:0], dsc_addr_ff});
      seg(16'h0003);
      chk("null", 1, seg_null_ff);
      seg(16'h000C);
      chk("ldt_pick", 48'h00CDAB0000D5, {tbl_base_ff[15:0], dsc_addr_ff});
      print_verdict();
   end
   // Hang guard
   initial
   begin
      #500000;
      n_mismatch++;
      print_verdict();
   end
endmodule
`default_nettype wire
